// ---- ssr_receiver.sv ----
// synchronous serial receiver: master or slave clocked, two-character fifo,
// overrun handling, 9-bit characters, plain register port.
// assumes pins come from outside the mclk domain; register port is local.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module ssr_receiver
  import ssr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ssr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ssr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ssr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic receive_data_pin_i,
  output logic receive_data_pin_oe_n,
  input wire logic transmit_clock_pin_i,
  output logic transmit_clock_pin_o,
  output logic transmit_clock_pin_oe_n,
  output logic receive_pin_gpio,
  output logic receive_irq
);
  import ssr_pkg::*;

  // pin synchronisers
  logic rx_s1_r, rx_s2_r, ck_s1_r, ck_s2_r, ck_s3_r;

  logic [7:0] ctrl_r, ctrl_nxt;
  logic [DIV_W-1:0] baud_r, baud_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  ssr_state_t state_r, state_nxt;
  logic [DIV_W-1:0] bcnt_r, bcnt_nxt;
  logic ck_r, ck_nxt;
  logic [3:0] nbit_r, nbit_nxt;
  logic [CHAR_W-1:0] shreg_r, shreg_nxt;
  logic [CHAR_W-1:0] fifo_r [FIFO_DEPTH];
  logic [CHAR_W-1:0] fifo_nxt [FIFO_DEPTH];
  logic rdp_r, rdp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic ovr_r, ovr_nxt;
  logic ovr_single_r, ovr_single_nxt;
  logic irq_r, irq_nxt;
  logic ck_oe_n_r, ck_oe_n_nxt;
  logic gpio_r, gpio_nxt;
  logic [3:0] fall_cnt_r, fall_cnt_nxt;
  logic halt_r, halt_nxt;
  // master trailing edges, delayed to meet the data pin behind its two flops
  logic [1:0] strb_r, strb_nxt;

  // fifo slot written next: oldest slot plus the current count
  function automatic logic wr_slot(input logic rdp, input logic [1:0] cnt);
    wr_slot = rdp ^ cnt[0];
  endfunction

  // one more bit completes the character
  function automatic logic is_last(input logic [3:0] n, input logic [3:0] bits);
    is_last = (n + 4'd1) == bits;
  endfunction

  logic port_en, master, single_receive_enable, continuous_receive_enable, rx9, enabled;
  logic [3:0] char_bits;
  logic trail, sample_bit, done;
  logic [CHAR_W-1:0] shifted, char_in;

  always_comb begin
    port_en = ctrl_r[CB_PORT_EN];
    master = ctrl_r[CB_MASTER];
    single_receive_enable = ctrl_r[CB_SINGLE_RECEIVE_ENABLE];
    continuous_receive_enable = ctrl_r[CB_CONTINUOUS_RECEIVE_ENABLE];
    rx9 = ctrl_r[CB_RX9];
    enabled = port_en & (single_receive_enable | continuous_receive_enable) & ~ovr_r;
    char_bits = rx9 ? BITS_9 : BITS_8;
    trail = 1'b0;
    sample_bit = rx_s2_r;
    done = 1'b0;
    shifted = {sample_bit, shreg_r[CHAR_W-1:1]};
    char_in = rx9 ? shifted : {1'b0, shifted[CHAR_W-1:1]};

    ctrl_nxt = ctrl_r;
    baud_nxt = baud_r;
    rdata_nxt = rdata_r;
    state_nxt = state_r;
    bcnt_nxt = bcnt_r;
    ck_nxt = ck_r;
    nbit_nxt = nbit_r;
    shreg_nxt = shreg_r;
    fifo_nxt = fifo_r;
    rdp_nxt = rdp_r;
    cnt_nxt = cnt_r;
    ovr_nxt = ovr_r;
    ovr_single_nxt = ovr_single_r;
    fall_cnt_nxt = fall_cnt_r;
    halt_nxt = halt_r;
    strb_nxt = {strb_r[0], 1'b0};

    // register reads; answer stands the cycle after the strobe only
    rdata_nxt = '0;
    if (reg_rd) begin
      if (reg_addr == OFS_CTRL) begin
        rdata_nxt = ctrl_r;
      end else if (reg_addr == OFS_STATUS) begin
        rdata_nxt = '0;
        rdata_nxt[SB_RECEIVE_COMPLETE_FLAG] = (cnt_r != 2'd0);
        rdata_nxt[SB_OVR] = ovr_r;
        rdata_nxt[SB_RECEIVED_NINTH_BIT] = fifo_r[rdp_r][CHAR_W-1];
        rdata_nxt[SB_BUSY] = (state_r == ST_SHIFT);
      end else if (reg_addr == OFS_DATA) begin
        rdata_nxt = fifo_r[rdp_r][DATA_W-1:0];
        if (cnt_r != 2'd0) begin
          rdp_nxt = ~rdp_r;
          cnt_nxt = cnt_r - 2'd1;
        end
        if (ovr_r && ovr_single_r) begin
          ovr_nxt = 1'b0;
        end
      end else if (reg_addr == OFS_BAUD_LO) begin
        rdata_nxt = baud_r[7:0];
      end else if (reg_addr == OFS_BAUD_HI) begin
        rdata_nxt = baud_r[15:8];
      end
    end

    // register writes
    if (reg_wr) begin
      if (reg_addr == OFS_CTRL) begin
        ctrl_nxt = reg_wdata;
        if (ovr_r && !ovr_single_r && !reg_wdata[CB_CONTINUOUS_RECEIVE_ENABLE]) begin
          ovr_nxt = 1'b0;
        end
      end else if (reg_addr == OFS_BAUD_LO) begin
        baud_nxt[7:0] = reg_wdata;
      end else if (reg_addr == OFS_BAUD_HI) begin
        baud_nxt[15:8] = reg_wdata;
      end
    end

    // trailing-edge detection for the active clock source
    if (master) begin
      // pin level at the driven trailing edge reaches rx_s2_r two cycles later
      trail = strb_r[1];
    end else begin
      trail = ck_s3_r & ~ck_s2_r;
    end

    case (state_r)
      ST_IDLE: begin
        ck_nxt = 1'b0;
        bcnt_nxt = '0;
        nbit_nxt = '0;
        fall_cnt_nxt = '0;
        halt_nxt = 1'b0;
        strb_nxt = '0;
        if (enabled) begin
          state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!enabled) begin
          // partial character dropped, clock parked low at once
          state_nxt = ST_IDLE;
          ck_nxt = 1'b0;
          nbit_nxt = '0;
          bcnt_nxt = '0;
          fall_cnt_nxt = '0;
          halt_nxt = 1'b0;
          strb_nxt = '0;
        end else begin
          if (master) begin
            // half period of the shift clock is baud+1 cycles
            if (bcnt_r == baud_r) begin
              bcnt_nxt = '0;
              if (!halt_r) begin
                ck_nxt = ~ck_r;
                if (ck_r) begin
                  strb_nxt[0] = 1'b1;
                  fall_cnt_nxt = fall_cnt_r + 4'd1;
                  if (is_last(fall_cnt_r, char_bits)) begin
                    // single receive: no further clock while the last bit is sampled
                    fall_cnt_nxt = '0;
                    halt_nxt = ~continuous_receive_enable;
                  end
                end
              end
            end else begin
              bcnt_nxt = bcnt_r + 1'b1;
            end
          end
          if (trail) begin
            shreg_nxt = shifted;
            nbit_nxt = nbit_r + 4'd1;
            if (is_last(nbit_r, char_bits)) begin
              done = 1'b1;
              nbit_nxt = '0;
            end
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase

    if (done) begin
      if (cnt_r == 2'(FIFO_DEPTH)) begin
        // fifo kept intact; the mode at the time picks the clear path
        ovr_nxt = 1'b1;
        ovr_single_nxt = single_receive_enable & ~continuous_receive_enable;
      end else begin
        fifo_nxt[wr_slot(rdp_nxt, cnt_nxt)] = char_in;
        cnt_nxt = cnt_nxt + 2'd1;
      end
      if (single_receive_enable) begin
        ctrl_nxt[CB_SINGLE_RECEIVE_ENABLE] = reg_wr && reg_addr == OFS_CTRL
                            && reg_wdata[CB_SINGLE_RECEIVE_ENABLE];
      end
      if (!continuous_receive_enable) begin
        state_nxt = ST_IDLE;
        ck_nxt = 1'b0;
      end
    end

    // port disable resets the whole receive path
    if (!port_en) begin
      state_nxt = ST_IDLE;
      rdp_nxt = 1'b0;
      cnt_nxt = '0;
      ovr_nxt = 1'b0;
      ck_nxt = 1'b0;
      nbit_nxt = '0;
      fall_cnt_nxt = '0;
      halt_nxt = 1'b0;
      strb_nxt = '0;
    end
  end

  always_comb begin
    irq_nxt = (cnt_nxt != 2'd0) & ctrl_nxt[CB_RECEIVE_INTERRUPT_ENABLE]
              & ctrl_nxt[CB_PERIPHERAL_IRQ_ENABLE] & ctrl_nxt[CB_GIE];
    ck_oe_n_nxt = ~(ctrl_nxt[CB_PORT_EN] & ctrl_nxt[CB_MASTER]);
    gpio_nxt = ~(ctrl_nxt[CB_PORT_EN]
                 & (ctrl_nxt[CB_SINGLE_RECEIVE_ENABLE] | ctrl_nxt[CB_CONTINUOUS_RECEIVE_ENABLE]));
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_s1_r <= 1'b0;
      rx_s2_r <= 1'b0;
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
    end else if (ce) begin
      rx_s1_r <= receive_data_pin_i;
      rx_s2_r <= rx_s1_r;
      ck_s1_r <= transmit_clock_pin_i;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      baud_r <= BAUD_RST;
      rdata_r <= '0;
      state_r <= ST_IDLE;
      bcnt_r <= '0;
      ck_r <= 1'b0;
      nbit_r <= '0;
      shreg_r <= '0;
      fifo_r[0] <= '0;
      fifo_r[1] <= '0;
      rdp_r <= 1'b0;
      cnt_r <= '0;
      ovr_r <= 1'b0;
      ovr_single_r <= 1'b0;
      irq_r <= 1'b0;
      ck_oe_n_r <= 1'b1;
      gpio_r <= 1'b1;
      fall_cnt_r <= '0;
      halt_r <= 1'b0;
      strb_r <= '0;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      baud_r <= baud_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      bcnt_r <= bcnt_nxt;
      ck_r <= ck_nxt;
      nbit_r <= nbit_nxt;
      shreg_r <= shreg_nxt;
      fifo_r <= fifo_nxt;
      rdp_r <= rdp_nxt;
      cnt_r <= cnt_nxt;
      ovr_r <= ovr_nxt;
      ovr_single_r <= ovr_single_nxt;
      irq_r <= irq_nxt;
      ck_oe_n_r <= ck_oe_n_nxt;
      gpio_r <= gpio_nxt;
      fall_cnt_r <= fall_cnt_nxt;
      halt_r <= halt_nxt;
      strb_r <= strb_nxt;
    end
  end

  // receive-only block: the data pin driver is never switched on
  logic dt_oe_n_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      dt_oe_n_r <= 1'b1;
    end else if (ce) begin
      dt_oe_n_r <= 1'b1;
    end
  end

  assign reg_rdata = rdata_r;
  assign receive_data_pin_oe_n = dt_oe_n_r;
  assign transmit_clock_pin_o = ck_r;
  assign transmit_clock_pin_oe_n = ck_oe_n_r;
  assign receive_pin_gpio = gpio_r;
  assign receive_irq = irq_r;
endmodule // ssr_receiver

// ---- ssr_pkg.sv ----
// constants for the synchronous serial receiver: register map, bit
// positions, reset values and states; shared by design and bench
package ssr_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CHAR_W = 9;
  localparam int DIV_W = 16;
  localparam int FIFO_DEPTH = 2;

  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_DATA = 4'h2;
  localparam logic [3:0] OFS_BAUD_LO = 4'h3;
  localparam logic [3:0] OFS_BAUD_HI = 4'h4;

  // control bit positions
  localparam int CB_PORT_EN = 0;
  localparam int CB_MASTER = 1;
  localparam int CB_SINGLE_RECEIVE_ENABLE = 2;
  localparam int CB_CONTINUOUS_RECEIVE_ENABLE = 3;
  localparam int CB_RX9 = 4;
  localparam int CB_RECEIVE_INTERRUPT_ENABLE = 5;
  localparam int CB_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int CB_GIE = 7;

  // status bit positions
  localparam int SB_RECEIVE_COMPLETE_FLAG = 0;
  localparam int SB_OVR = 1;
  localparam int SB_RECEIVED_NINTH_BIT = 2;
  localparam int SB_BUSY = 3;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } ssr_state_t;
endpackage

// ---- ssr_receiver_checker.sv ----
// port-level assertions for the serial receiver
// assumes ssr_pkg is compiled first; bound to every ssr_receiver
`timescale 1ns/1ps
module ssr_checker
  import ssr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ssr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ssr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ssr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic receive_data_pin_oe_n,
  input wire logic transmit_clock_pin_o,
  input wire logic transmit_clock_pin_oe_n,
  input wire logic receive_pin_gpio,
  input wire logic receive_irq
);
  logic [7:0] ctl_r;
  logic [3:0] nr_r;
  logic ck_q;
  logic wr_ctl;
  logic pm;
  logic ie;
  logic pe;
  assign wr_ctl = reg_wr && reg_addr == OFS_CTRL;
  assign pm = ctl_r[CB_PORT_EN] && ctl_r[CB_MASTER];
  assign ie = &ctl_r[7:5];
  assign pe = ctl_r[CB_PORT_EN];
  // shadow of software writes only; hardware clearing of single rx is not seen
  always_ff @(posedge mclk) begin
    ck_q <= transmit_clock_pin_o;
    ctl_r <= rst ? 8'h00 : (wr_ctl ? reg_wdata : ctl_r);
    if (rst || wr_ctl) nr_r <= 4'h0;
    else if (transmit_clock_pin_o && !ck_q) nr_r <= nr_r + 4'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_DATA_OE: assert property (receive_data_pin_oe_n)
    else $error("data pin driver enabled");
  AST_CLK_OE: assert property (transmit_clock_pin_oe_n == !pm)
    else $error("clock pin driver state wrong");
  AST_ONE_CHAR: assert property (!ctl_r[CB_CONTINUOUS_RECEIVE_ENABLE] |-> nr_r <= (ctl_r[CB_RX9] ? 4'h9 : 4'h8))
    else $error("too many clocks for one character");
  AST_CK_STOP: assert property (wr_ctl && reg_wdata[3:2] == 2'h0 |->
    ##2 !transmit_clock_pin_o [*2])
    else $error("clock kept running");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  AST_IRQ_EN: assert property (receive_irq |-> ie)
    else $error("interrupt while masked");
  AST_IRQ_CLR: assert property (wr_ctl && !reg_wdata[CB_PORT_EN] |-> ##2 !receive_irq)
    else $error("interrupt after port disable");
  AST_GPIO: assert property (!pe |-> receive_pin_gpio)
    else $error("pin not released");
  COV_IRQ: cover property ($rose(receive_irq));
  COV_CK: cover property ($rose(transmit_clock_pin_o));
  COV_RD: cover property ($past(reg_rd) && reg_rdata != 8'h00);
endmodule // ssr_checker
bind ssr_receiver ssr_checker chk (.*);

// ---- ssr_partner.sv ----
// far-side sender: data on the leading edge, own clock in slave mode
// assumes ck is the resolved clock pin level
`timescale 1ns/1ps
module ssr_partner (
  input wire logic ck,
  input wire logic go,
  input wire logic clr,
  input wire logic [31:0] stream,
  output logic sck,
  output logic dat
);
  int idx = 0;
  initial sck = 1'h0;
  initial dat = 1'h0;
  always @(posedge ck or posedge clr) begin
    if (clr) idx = 0;
    else begin
      dat = stream[idx];
      idx = (idx + 1) % 32;
    end
  end
  // only one character of clocks, then the data line is inverted
  always @(posedge go) begin
    // stay clear of the receiver clock edges
    #5;
    repeat (8) begin
      #100 sck = 1'h1;
      #100 sck = 1'h0;
    end
    #100 dat = ~dat;
  end
endmodule // ssr_partner

// ---- ssr_receiver_tb_top.sv ----
// self-checking bench for the serial receiver
// assumes ssr_pkg, checker and partner model are compiled first
`timescale 1ns/1ps
module ssr_receiver_tb_top;
  import ssr_pkg::*;
  logic mclk = 1'h0;
  logic rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, go = 1'h0, clr = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
  logic [31:0] stream = 32'hB24D961E;
  logic dat, sck, ck_wire, dat_oe_n, ck_o, ck_oe_n, gpio, irq;
  int mismatches = 0, checks_done = 0;
  assign ck_wire = ck_oe_n ? sck : ck_o;
  ssr_receiver dut (.mclk(mclk), .rst(rst), .ce(1'h1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .receive_data_pin_i(dat), .receive_data_pin_oe_n(dat_oe_n),
    .transmit_clock_pin_i(ck_wire), .transmit_clock_pin_o(ck_o),
    .transmit_clock_pin_oe_n(ck_oe_n), .receive_pin_gpio(gpio), .receive_irq(irq));
  ssr_partner mdl (.ck(ck_wire), .go(go), .clr(clr), .stream(stream), .sck(sck), .dat(dat));
  initial forever #12.5 mclk = ~mclk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
  endtask
  task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
    int n = 0;
    do begin
      rd(OFS_STATUS, d);
      n++;
    end while ((d & m) !== v && n < 400);
    if (n >= 400) begin
      mismatches++;
      $display("wrong value at %0t: status wait ran out", $time);
      end_of_test();
    end
  endtask
  // port disable empties the fifo so every test starts clean
  task automatic rewind(input logic [31:0] s);
    stream <= s;
    clr <= 1'h1;
    wr(OFS_CTRL, 8'h00);
    clr <= 1'h0;
  endtask
  task automatic t_reset();
    for (int a = 0; a < 5; a++) begin
      rd(a[3:0], d);
      cmp(d, 8'h00);
    end
    rd(4'hF, d);
    cmp(d, 8'h00);
    cmp({7'h0, gpio}, 8'h01);
    cmp({7'h0, dat_oe_n}, 8'h01);
    $display("reset test done");
  endtask
  task automatic t_single(input logic [7:0] c, input logic [7:0] st, input logic [8:0] ch);
    rewind({23'h0, ch});
    wr(OFS_CTRL, c);
    wait_st(8'h09, 8'h01);
    rd(OFS_CTRL, d);
    cmp(d, c & 8'hFB);
    rd(OFS_STATUS, d);
    cmp(d, st);
    rd(OFS_DATA, d);
    cmp(d, ch[7:0]);
    rd(OFS_STATUS, d);
    cmp(d, 8'h00);
    $display("single test done");
  endtask
  task automatic t_cont();
    rewind(32'hB24D961E);
    wr(OFS_CTRL, 8'hEF);
    wait_st(8'h02, 8'h02);
    cmp({7'h0, irq}, 8'h01);
    rd(OFS_CTRL, d);
    cmp(d, 8'hEB);
    wr(OFS_CTRL, 8'h2B);
    repeat (2) @(posedge mclk);
    #1 cmp({7'h0, irq}, 8'h00);
    rd(OFS_DATA, d);
    cmp(d, 8'h1E);
    rd(OFS_DATA, d);
    cmp(d, 8'h96);
    rd(OFS_STATUS, d);
    cmp(d, 8'h02);
    wr(OFS_CTRL, 8'h23);
    rd(OFS_STATUS, d);
    cmp(d, 8'h00);
    $display("continuous test done");
  endtask
  task automatic t_sov();
    rewind(32'hB24D961E);
    repeat (3) begin
      wr(OFS_CTRL, 8'h07);
      wait_st(8'h08, 8'h00);
    end
    rd(OFS_STATUS, d);
    cmp(d & 8'h03, 8'h03);
    rd(OFS_DATA, d);
    cmp(d, 8'h1E);
    rd(OFS_STATUS, d);
    cmp(d, 8'h01);
    $display("single overrun test done");
  endtask
  task automatic t_abort();
    rewind(32'hB24D961E);
    wr(OFS_BAUD_LO, 8'h04);
    wr(OFS_BAUD_HI, 8'h00);
    wr(OFS_CTRL, 8'h03);
    wr(OFS_CTRL, 8'h0B);
    repeat (30) @(posedge mclk);
    wr(OFS_CTRL, 8'h03);
    repeat (20) @(posedge mclk);
    rd(OFS_STATUS, d);
    cmp(d, 8'h00);
    rd(OFS_BAUD_LO, d);
    cmp(d, 8'h04);
    wr(OFS_BAUD_LO, 8'h00);
    $display("abort test done");
  endtask
  task automatic t_slave();
    rewind(32'hB24D961E);
    wr(OFS_CTRL, 8'h09);
    go <= 1'h1;
    @(posedge mclk);
    go <= 1'h0;
    wait_st(8'h01, 8'h01);
    cmp({7'h0, ck_oe_n}, 8'h01);
    rd(OFS_DATA, d);
    cmp(d, 8'h1E);
    $display("slave test done");
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'h0;
    t_reset();
    t_single(8'h07, 8'h01, 9'h01E);
    t_single(8'h17, 8'h05, 9'h1A3);
    t_cont();
    t_sov();
    t_abort();
    t_slave();
    end_of_test();
  end
endmodule // ssr_receiver_tb_top
